// ===== design/fpp_top.sv
// Fuse programming pulse logic: key, code, trial, blow, lock and power-up calibration.
//
// Function
// - Calibration enabled: hold quiescent duty after power-on.
// - After calibration interval, output follows the field.
// - Interval is a fixed count of carrier periods.
// - Calibration only after its enable fuse blown.
// - Low, mid, high levels; pulses return to low.
// - Trial applies one register only, lost at power-off.
// - Blow sets fuses; more registers may follow.
// - Blown lock fuse rejects all further programming.
// - Key mid-pulse count is the register number.
// - Code mid-pulse count is the fuse pattern.
// - Each fuse is one bit; code drives parameter.
// - High pulse blows addressed fuses; never reverts.
// - Supply cycle clears trials and unblown locations.
// - Addressed setting applies to output at once.
// - Each code pulse adds one, saturating at maximum.
`timescale 1ns/10ps
`include "fpp_map.svh"
module fpp_top #(
    parameter int NUM_REG     = `FPP_NUM_REG,
    parameter int FIELD_W     = `FPP_FIELD_W,
    parameter int KEY_W       = `FPP_KEY_W,
    parameter int CAL_REG     = `FPP_CAL_REG,
    parameter int LOCK_REG    = `FPP_LOCK_REG,
    parameter int CAL_BIT     = `FPP_CAL_BIT,
    parameter int CAL_PERIODS = `FPP_CAL_PERIODS,
    parameter int ACTIVE_CYC  = `FPP_ACTIVE_CYC
) (
    input  wire logic                           i_core_clk,
    input  wire logic                           i_reset_n,
    input  wire logic                           i_clk_en,
    input  wire logic                           i_modulated_output_pin_mid,
    input  wire logic                           i_modulated_output_pin_high,
    input  wire logic [NUM_REG-1:0][FIELD_W-1:0] i_fuse,
    input  wire logic                           i_carrier_tick,
    output logic      [NUM_REG-1:0][FIELD_W-1:0] o_param,
    output logic                                o_cal_hold,
    output logic                                o_blow_en,
    output logic      [KEY_W-1:0]               o_blow_reg,
    output logic      [FIELD_W-1:0]             o_blow_bits,
    output logic      [KEY_W-1:0]               o_sel_reg,
    output logic                                o_locked
);
    localparam int CAL_CW = $clog2(CAL_PERIODS + 1);

    typedef struct packed {
        fpp_pkg::fpp_state_e            st;
        logic [KEY_W-1:0]               key;
        logic [KEY_W-1:0]               sel;
        logic [FIELD_W-1:0]             trial;
        logic [NUM_REG-1:0][FIELD_W-1:0] param;
        logic                           cal_pend;
        logic [CAL_CW-1:0]              cal_cnt;
        logic                           cal_hold;
        logic                           blow_en;
        logic [KEY_W-1:0]               blow_reg;
        logic [FIELD_W-1:0]             blow_bits;
        logic                           locked;
    } fpp_top_s;

    // Supply cycle is the reset: every trial is gone and calibration is pending again.
    localparam fpp_top_s RST = '{st: fpp_pkg::FPP_ST_IDLE, key: '0, sel: '0, trial: '0,
                                 param: '0, cal_pend: 1'b1, cal_cnt: '0, cal_hold: 1'b0,
                                 blow_en: 1'b0, blow_reg: '0, blow_bits: '0, locked: 1'b0};

    fpp_top_s            q;
    fpp_top_s            d;
    fpp_pkg::fpp_pulse_s pulse;
    logic                high_lvl;
    logic                lock_fuse;
    logic                cal_fuse;

    generate
        if (NUM_REG >= (1 << KEY_W) || CAL_REG > NUM_REG || LOCK_REG > NUM_REG
            || CAL_REG < 1 || LOCK_REG < 1 || CAL_BIT >= FIELD_W || CAL_PERIODS < 1
            || FIELD_W < 1) begin : g_bad_cfg
            $error("fpp_top parameters out of range");
        end
    endgenerate

    // Returns the fuse field of a one-based register number, zero for none.
    function automatic logic [FIELD_W-1:0] sel_field(
        input logic [NUM_REG-1:0][FIELD_W-1:0] f,
        input logic [KEY_W-1:0]                s
    );
        sel_field = '0;
        for (int r = 0; r < NUM_REG; r++) begin
            if (s == KEY_W'(r + 1)) begin
                sel_field = f[r];
            end
        end
    endfunction

    fpp_pin_cls #(
        .ACTIVE_CYC (ACTIVE_CYC)
    ) u_pin_cls (
        .i_core_clk       (i_core_clk),
        .i_reset_n        (i_reset_n),
        .i_clk_en         (i_clk_en),
        .i_pin_above_mid  (i_modulated_output_pin_mid),
        .i_pin_above_high (i_modulated_output_pin_high),
        .o_pulse          (pulse),
        .o_high_level     (high_lvl)
    );

    assign lock_fuse = |i_fuse[LOCK_REG-1];
    assign cal_fuse  = i_fuse[CAL_REG-1][CAL_BIT];

    always_comb begin
        d         = q;
        d.blow_en = 1'b0;
        case (q.st)
            fpp_pkg::FPP_ST_IDLE: begin
                if (pulse.high_level_pulse) begin
                    d.st  = fpp_pkg::FPP_ST_KEY;
                    d.key = '0;
                end
            end
            fpp_pkg::FPP_ST_KEY: begin
                if (pulse.mid_level_pulse && q.key != '1) begin
                    d.key = q.key + 1'b1;
                end else if (pulse.high_level_pulse) begin
                    if (q.key != '0 && q.key <= KEY_W'(NUM_REG)) begin
                        // A new selection drops any trial held on another register.
                        d.st    = fpp_pkg::FPP_ST_CODE;
                        d.sel   = q.key;
                        d.trial = '0;
                    end else begin
                        d.st = fpp_pkg::FPP_ST_IDLE;
                    end
                end
            end
            fpp_pkg::FPP_ST_CODE: begin
                if (pulse.mid_level_pulse) begin
                    if (q.trial != '1) begin
                        d.trial = q.trial + 1'b1;
                    end
                end else if (pulse.high_level_pulse) begin
                    // A blow pulse leaves blow on its mid ramp, so its count arrives here.
                    d.st    = fpp_pkg::FPP_ST_IDLE;
                    d.sel   = '0;
                    d.trial = '0;
                end else if (high_lvl) begin
                    d.st = fpp_pkg::FPP_ST_BLOW;
                end
            end
            fpp_pkg::FPP_ST_BLOW: begin
                // Fuse drivers follow the high level; only unblown addressed bits are driven.
                d.blow_en   = high_lvl;
                d.blow_reg  = q.sel;
                d.blow_bits = q.trial & ~sel_field(i_fuse, q.sel);
                if (pulse.high_level_pulse) begin
                    d.st    = fpp_pkg::FPP_ST_IDLE;
                    d.sel   = '0;
                    d.trial = '0;
                end else if (!high_lvl) begin
                    d.st = fpp_pkg::FPP_ST_CODE;
                end
            end
            default: begin
                d.st = fpp_pkg::FPP_ST_IDLE;
            end
        endcase

        if (lock_fuse) begin
            d.st      = fpp_pkg::FPP_ST_IDLE;
            d.sel     = '0;
            d.trial   = '0;
            d.blow_en = 1'b0;
        end
        d.locked = lock_fuse;

        // Blown fuses combine bitwise into each parameter, and the live trial into the selected parameter only.
        for (int r = 0; r < NUM_REG; r++) begin
            d.param[r] = i_fuse[r] | ((q.sel == KEY_W'(r + 1)) ? q.trial : '0);
        end

        // Calibration counts carrier periods, so it stretches as the carrier slows.
        if (q.cal_pend && cal_fuse && i_carrier_tick) begin
            if (q.cal_cnt == CAL_CW'(CAL_PERIODS - 1)) begin
                d.cal_pend = 1'b0;
            end else begin
                d.cal_cnt = q.cal_cnt + 1'b1;
            end
        end
        d.cal_hold = d.cal_pend && cal_fuse;
    end

    always_ff @(posedge i_core_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            q <= RST;
        end else if (i_clk_en) begin
            q <= d;
        end
    end

    assign o_param     = q.param;
    assign o_cal_hold  = q.cal_hold;
    assign o_blow_en   = q.blow_en;
    assign o_blow_reg  = q.blow_reg;
    assign o_blow_bits = q.blow_bits;
    assign o_sel_reg   = q.sel;
    assign o_locked    = q.locked;

    logic [FIELD_W-1:0] a_sel_fuse;
    logic [FIELD_W-1:0] a_sel_param;
    assign a_sel_fuse  = sel_field(i_fuse, q.sel);
    assign a_sel_param = sel_field(q.param, q.sel);

    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (!i_reset_n);

    sequence s_key_done;
        i_clk_en && q.st == fpp_pkg::FPP_ST_KEY && pulse.high_level_pulse
            && !pulse.mid_level_pulse && !lock_fuse;
    endsequence

    sequence s_blow_done;
        i_clk_en && (q.st == fpp_pkg::FPP_ST_BLOW || q.st == fpp_pkg::FPP_ST_CODE)
            && pulse.high_level_pulse && !lock_fuse;
    endsequence

    property p_cal_start;
        $rose(i_reset_n) |-> q.cal_pend && q.cal_cnt == '0 && q.trial == '0 && q.sel == '0;
    endproperty
    a_cal_start: assert property (p_cal_start)
        else $error("state not cleared after power-on");

    property p_cal_end;
        $fell(q.cal_pend) |->
            $past(q.cal_cnt) == CAL_CW'(CAL_PERIODS - 1) && $past(i_carrier_tick);
    endproperty
    a_cal_end: assert property (p_cal_end)
        else $error("calibration ended at the wrong carrier count");

    property p_cal_off;
        !q.cal_pend |=> !q.cal_pend ##0 !o_cal_hold;
    endproperty
    a_cal_off: assert property (p_cal_off)
        else $error("calibration hold returned after it ended");

    property p_cal_fuse;
        !cal_fuse && i_clk_en |=> !o_cal_hold;
    endproperty
    a_cal_fuse: assert property (p_cal_fuse)
        else $error("calibration hold without its enable fuse");

    property p_select;
        s_key_done ##0 (q.key != '0 && q.key <= KEY_W'(NUM_REG)) |=>
            q.st == fpp_pkg::FPP_ST_CODE && q.trial == '0 && q.sel == $past(q.key);
    endproperty
    a_select: assert property (p_select)
        else $error("register selection wrong");

    property p_trial_inc;
        i_clk_en && q.st == fpp_pkg::FPP_ST_CODE && pulse.mid_level_pulse && !lock_fuse |=>
            q.trial == (($past(q.trial) == '1) ? $past(q.trial)
                                               : FIELD_W'($past(q.trial) + 1'b1));
    endproperty
    a_trial_inc: assert property (p_trial_inc)
        else $error("code pulse did not step the trial value by one");

    property p_param_live;
        i_clk_en && q.sel != '0 && d.sel == q.sel |=>
            a_sel_param == ($past(a_sel_fuse) | $past(q.trial));
    endproperty
    a_param_live: assert property (p_param_live)
        else $error("addressed setting not applied to the parameter");

    property p_blow_end;
        s_blow_done |=> q.st == fpp_pkg::FPP_ST_IDLE ##0 q.sel == '0;
    endproperty
    a_blow_end: assert property (p_blow_end)
        else $error("blow pulse did not end the selection");

    property p_blow_bits;
        // The blow bits were formed from the fuse state of the cycle before.
        o_blow_en |-> o_blow_reg != '0
            && (o_blow_bits & sel_field($past(i_fuse), o_blow_reg)) == '0;
    endproperty
    a_blow_bits: assert property (p_blow_bits)
        else $error("blow driven on an unselected register or blown bit");

    property p_lock;
        lock_fuse && i_clk_en |=> q.st == fpp_pkg::FPP_ST_IDLE && !o_blow_en && q.sel == '0;
    endproperty
    a_lock: assert property (p_lock)
        else $error("programming accepted while locked");

endmodule // fpp_top

// ===== design/fpp_map.svh
// Register numbers, field sizes, bit positions and timing counts of the fuse programming logic.
`ifndef FPP_MAP_SVH
`define FPP_MAP_SVH

`define FPP_CLK_PERIOD_NS 100
`define FPP_T_ACTIVE_NS   40000
`define FPP_ACTIVE_CYC    ((`FPP_T_ACTIVE_NS + `FPP_CLK_PERIOD_NS - 1) / `FPP_CLK_PERIOD_NS)
`define FPP_CAL_TIME_MS   800
`define FPP_CAL_REF_HZ    125
`define FPP_CAL_PERIODS   ((`FPP_CAL_TIME_MS * `FPP_CAL_REF_HZ) / 1000)
`define FPP_NUM_REG       5
`define FPP_FIELD_W       8
`define FPP_KEY_W         3
`define FPP_CAL_REG       4
`define FPP_LOCK_REG      5
`define FPP_CAL_BIT       0

`endif

// ===== design/fpp_pkg.sv
// Types shared by the fuse programming pulse logic.
package fpp_pkg;

    typedef enum logic [3:0] {
        FPP_ST_IDLE = 4'h1,
        FPP_ST_KEY  = 4'h2,
        FPP_ST_CODE = 4'h4,
        FPP_ST_BLOW = 4'h8
    } fpp_state_e;

    typedef enum logic [2:0] {
        FPP_LVL_LOW  = 3'h1,
        FPP_LVL_MID  = 3'h2,
        FPP_LVL_HIGH = 3'h4
    } fpp_lvl_e;

    typedef struct packed {
        logic mid_level_pulse;
        logic high_level_pulse;
    } fpp_pulse_s;

endpackage

// ===== design/fpp_pin_cls.sv
// Pin level classifier: turns the pin comparators into counted pulse events.
`timescale 1ns/10ps
`include "fpp_map.svh"
module fpp_pin_cls #(
    parameter int ACTIVE_CYC = `FPP_ACTIVE_CYC
) (
    input  wire logic              i_core_clk,
    input  wire logic              i_reset_n,
    input  wire logic              i_clk_en,
    input  wire logic              i_pin_above_mid,
    input  wire logic              i_pin_above_high,
    output fpp_pkg::fpp_pulse_s    o_pulse,
    output logic                   o_high_level
);
    localparam int CW = $clog2(ACTIVE_CYC + 1);

    typedef struct packed {
        logic [1:0]         mid_sync;
        logic [1:0]         high_sync;
        fpp_pkg::fpp_lvl_e  peak;
        logic [CW-1:0]      dur;
        fpp_pkg::fpp_pulse_s pulse;
        logic               high_lvl;
    } fpp_cls_s;

    localparam fpp_cls_s RST = '{mid_sync: 2'h0, high_sync: 2'h0, peak: fpp_pkg::FPP_LVL_LOW,
                                 dur: '0, pulse: 2'h0, high_lvl: 1'b0};

    fpp_cls_s          q;
    fpp_cls_s          d;
    fpp_pkg::fpp_lvl_e lvl;

    generate
        if (ACTIVE_CYC < 1) begin : g_bad_width
            $error("ACTIVE_CYC must be at least one cycle");
        end
    endgenerate

    always_comb begin
        d           = q;
        d.mid_sync  = {q.mid_sync[0], i_pin_above_mid};
        d.high_sync = {q.high_sync[0], i_pin_above_high};
        d.pulse     = 2'h0;
        if (q.high_sync[1]) begin
            lvl = fpp_pkg::FPP_LVL_HIGH;
        end else if (q.mid_sync[1]) begin
            lvl = fpp_pkg::FPP_LVL_MID;
        end else begin
            lvl = fpp_pkg::FPP_LVL_LOW;
        end
        d.high_lvl = (lvl == fpp_pkg::FPP_LVL_HIGH);
        if (lvl == fpp_pkg::FPP_LVL_LOW) begin
            // A pulse counts only on its return to low, and only if it lasted long enough.
            if (q.peak != fpp_pkg::FPP_LVL_LOW && q.dur == CW'(ACTIVE_CYC)) begin
                d.pulse.mid_level_pulse  = (q.peak == fpp_pkg::FPP_LVL_MID);
                d.pulse.high_level_pulse = (q.peak == fpp_pkg::FPP_LVL_HIGH);
            end
            d.peak = fpp_pkg::FPP_LVL_LOW;
            d.dur  = '0;
        end else begin
            if (lvl == fpp_pkg::FPP_LVL_HIGH) begin
                d.peak = fpp_pkg::FPP_LVL_HIGH;
            end else if (q.peak == fpp_pkg::FPP_LVL_LOW) begin
                d.peak = fpp_pkg::FPP_LVL_MID;
            end
            if (q.dur != CW'(ACTIVE_CYC)) begin
                d.dur = q.dur + 1'b1;
            end
        end
    end

    always_ff @(posedge i_core_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            q <= RST;
        end else if (i_clk_en) begin
            q <= d;
        end
    end

    assign o_pulse      = q.pulse;
    assign o_high_level = q.high_lvl;

    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (!i_reset_n);

    property p_mid_pulse_width;
        $rose(o_pulse.mid_level_pulse) |->
            $past(q.dur) == CW'(ACTIVE_CYC) && $past(q.peak) == fpp_pkg::FPP_LVL_MID;
    endproperty
    a_mid_pulse_width: assert property (p_mid_pulse_width)
        else $error("mid pulse counted without a full mid excursion");

    property p_high_pulse_on_low;
        $rose(o_pulse.high_level_pulse) |->
            $past(q.peak) == fpp_pkg::FPP_LVL_HIGH && !$past(q.high_sync[1]) && !o_high_level;
    endproperty
    a_high_pulse_on_low: assert property (p_high_pulse_on_low)
        else $error("high pulse counted before the pin returned low");

endmodule // fpp_pin_cls

// ===== test/fpp_prog_model.sv
// Behavioural programmer that drives three-level pulses onto the pin comparators.
`timescale 1ns/10ps
module fpp_prog_model #(
    parameter int WIDTH_CYC = 8
) (
    input  wire logic i_core_clk,
    output logic      o_pin_mid,
    output logic      o_pin_high
);
    initial begin
        o_pin_mid  = 1'b0;
        o_pin_high = 1'b0;
    end

    // Keeps the pin low for n edges and leaves the caller in the settled half of the cycle.
    task automatic hold_low(input int n);
        repeat (n) @(posedge i_core_clk);
        @(negedge i_core_clk);
    endtask

    // A mid pulse is low, mid, low; the trailing low gap separates pulses.
    task automatic mid_pulse(input int w);
        @(posedge i_core_clk);
        o_pin_mid <= 1'b1;
        repeat (w) @(posedge i_core_clk);
        o_pin_mid <= 1'b0;
        hold_low(8);
    endtask

    // A high pulse passes through the mid level on its way up and down.
    task automatic high_pulse(input int w);
        @(posedge i_core_clk);
        o_pin_mid <= 1'b1;
        repeat (2) @(posedge i_core_clk);
        o_pin_high <= 1'b1;
        repeat (w) @(posedge i_core_clk);
        o_pin_high <= 1'b0;
        repeat (2) @(posedge i_core_clk);
        o_pin_mid <= 1'b0;
        hold_low(8);
    endtask

    task automatic send_pulses(input int n);
        repeat (n) mid_pulse(WIDTH_CYC);
    endtask

    // Register selection is a high pulse, the key, then a second high pulse.
    task automatic select(input int key);
        high_pulse(WIDTH_CYC);
        send_pulses(key);
        high_pulse(WIDTH_CYC);
    endtask
endmodule // fpp_prog_model

// ===== test/testbench.sv
// Self-checking bench of the fuse programming pulse logic with a fuse array model.
`timescale 1ns/10ps
module testbench;
    logic                  i_core_clk;
    logic                  i_reset_n;
    logic                  i_clk_en;
    logic                  i_carrier_tick;
    logic                  pin_mid;
    logic                  pin_high;
    logic [4:0][7:0]       fuse_q;
    logic [4:0][7:0]       o_param;
    logic                  o_cal_hold;
    logic                  o_blow_en;
    logic [2:0]            o_blow_reg;
    logic [7:0]            o_blow_bits;
    logic [2:0]            o_sel_reg;
    logic                  o_locked;
    logic                  blow_seen;
    logic [7:0]            blow_bits_q;
    logic [2:0]            blow_reg_q;
    int                    mismatches;
    int                    checks_done;

    fpp_top #(.CAL_PERIODS(3), .ACTIVE_CYC(4)) dut_u (
        .i_core_clk                  (i_core_clk),
        .i_reset_n                   (i_reset_n),
        .i_clk_en                    (i_clk_en),
        .i_modulated_output_pin_mid  (pin_mid),
        .i_modulated_output_pin_high (pin_high),
        .i_fuse                      (fuse_q),
        .i_carrier_tick              (i_carrier_tick),
        .o_param                     (o_param),
        .o_cal_hold                  (o_cal_hold),
        .o_blow_en                   (o_blow_en),
        .o_blow_reg                  (o_blow_reg),
        .o_blow_bits                 (o_blow_bits),
        .o_sel_reg                   (o_sel_reg),
        .o_locked                    (o_locked)
    );

    fpp_prog_model #(.WIDTH_CYC(8)) prog_u (
        .i_core_clk (i_core_clk),
        .o_pin_mid  (pin_mid),
        .o_pin_high (pin_high)
    );

    initial begin
        i_core_clk = 1'b0;
        forever #50 i_core_clk = ~i_core_clk;
    end

    // Blown fuses survive reset; the array only ever gains bits.
    initial fuse_q = '0;
    always @(posedge i_core_clk) begin
        if (o_blow_en && o_blow_reg != 3'h0) begin
            fuse_q[o_blow_reg - 3'h1] <= fuse_q[o_blow_reg - 3'h1] | o_blow_bits;
            blow_seen   <= 1'b1;
            blow_bits_q <= blow_bits_q | o_blow_bits;
            blow_reg_q  <= o_blow_reg;
        end
    end

    task automatic chk_v(input string name, input logic [7:0] exp, input logic [7:0] got);
        checks_done++;
        if (got !== exp) begin
            mismatches++;
            $display("[ERR] %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic chk_b(input string name, input logic exp, input logic got);
        checks_done++;
        if (got !== exp) begin
            mismatches++;
            $display("[ERR] %s expected %b seen %b", name, exp, got);
        end
    endtask

    task automatic close_out();
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    task automatic do_reset();
        @(posedge i_core_clk);
        i_reset_n <= 1'b0;
        repeat (8) @(posedge i_core_clk);
        i_reset_n <= 1'b1;
        repeat (3) @(posedge i_core_clk);
        @(negedge i_core_clk);
    endtask

    task automatic tick();
        @(posedge i_core_clk);
        i_carrier_tick <= 1'b1;
        @(posedge i_core_clk);
        i_carrier_tick <= 1'b0;
        repeat (3) @(posedge i_core_clk);
        @(negedge i_core_clk);
    endtask

    task automatic blow_code(input int key, input int code);
        prog_u.select(key);
        prog_u.send_pulses(code);
        blow_seen   = 1'b0;
        blow_bits_q = 8'h00;
        prog_u.high_pulse(8);
    endtask

    // A high pulse after a code blows it, so another register needs a supply cycle first.
    task automatic t_trial();
        prog_u.select(2);
        chk_v("sel_reg", 8'h02, 8'(o_sel_reg));
        prog_u.send_pulses(3);
        chk_v("param2", 8'h03, o_param[1]);
        prog_u.mid_pulse(2);
        chk_v("param2 short", 8'h03, o_param[1]);
        do_reset();
        chk_v("param2 dropped", 8'h00, o_param[1]);
        prog_u.select(3);
        prog_u.send_pulses(1);
        chk_v("param3", 8'h01, o_param[2]);
        chk_v("param2 alone", 8'h00, o_param[1]);
        do_reset();
    endtask

    task automatic t_saturate();
        prog_u.select(1);
        prog_u.send_pulses(256);
        chk_v("param1 max", 8'hff, o_param[0]);
        do_reset();
        chk_v("param1 cleared", 8'h00, o_param[0]);
        chk_v("sel cleared", 8'h00, 8'(o_sel_reg));
    endtask

    task automatic t_blow();
        blow_code(1, 5);
        chk_b("blow_en", 1'b1, blow_seen);
        chk_v("blow_bits", 8'h05, blow_bits_q);
        chk_v("blow_reg", 8'h01, 8'(blow_reg_q));
        chk_v("param1 blown", 8'h05, o_param[0]);
        blow_code(1, 7);
        chk_v("blow_bits again", 8'h02, blow_bits_q);
        chk_v("param1 merged", 8'h07, o_param[0]);
        blow_code(2, 3);
        chk_v("param2 blown", 8'h03, o_param[1]);
        do_reset();
        chk_v("param1 kept", 8'h07, o_param[0]);
        chk_v("param2 kept", 8'h03, o_param[1]);
    endtask

    task automatic t_cal();
        chk_b("cal off", 1'b0, o_cal_hold);
        blow_code(4, 1);
        do_reset();
        chk_b("cal hold", 1'b1, o_cal_hold);
        tick();
        tick();
        chk_b("cal still", 1'b1, o_cal_hold);
        tick();
        chk_b("cal done", 1'b0, o_cal_hold);
        tick();
        chk_b("cal stays", 1'b0, o_cal_hold);
    endtask

    // A low clock enable freezes the classifier too, so a pulse sent meanwhile is lost.
    task automatic t_freeze();
        prog_u.select(3);
        prog_u.send_pulses(2);
        @(posedge i_core_clk);
        i_clk_en <= 1'b0;
        prog_u.send_pulses(1);
        chk_v("param3 frozen", 8'h02, o_param[2]);
        chk_v("sel frozen", 8'h03, 8'(o_sel_reg));
        @(posedge i_core_clk);
        i_clk_en <= 1'b1;
        prog_u.send_pulses(1);
        chk_v("param3 resumed", 8'h03, o_param[2]);
        do_reset();
    endtask

    task automatic t_lock();
        blow_code(5, 1);
        chk_b("locked", 1'b1, o_locked);
        prog_u.select(2);
        prog_u.send_pulses(1);
        chk_v("sel refused", 8'h00, 8'(o_sel_reg));
        chk_v("param2 locked", 8'h03, o_param[1]);
        do_reset();
        chk_b("lock kept", 1'b1, o_locked);
    endtask

    initial begin
        i_reset_n      = 1'b0;
        i_clk_en       = 1'b1;
        i_carrier_tick = 1'b0;
        mismatches     = 0;
        checks_done    = 0;
        blow_seen      = 1'b0;
        blow_bits_q    = 8'h00;
        blow_reg_q     = 3'h0;
        repeat (8) @(posedge i_core_clk);
        @(negedge i_core_clk);
        chk_v("param1 rst", 8'h00, o_param[0]);
        chk_b("blow_en rst", 1'b0, o_blow_en);
        @(posedge i_core_clk);
        i_reset_n <= 1'b1;
        repeat (3) @(posedge i_core_clk);
        t_trial();
        t_saturate();
        t_blow();
        t_cal();
        t_freeze();
        t_lock();
        close_out();
    end

    // Whole run is about 6000 cycles; this limit leaves ample margin.
    initial begin
        repeat (60000) @(posedge i_core_clk);
        mismatches++;
        close_out();
    end
endmodule // testbench
